// file: rtl/tx_consts.svh
// register map, field positions and timing constants of the transmitter control block
`ifndef TX_CONSTS_SVH
`define TX_CONSTS_SVH
`define ADDR_PROFILE_ZERO 8'h0c
`define ADDR_PROFILE_ONE 8'h0d
`define ADDR_LOW_POWER_DUTY 8'h0e
`define ADDR_RAMP_RATE 8'h0f
`define ADDR_CMP_DIVIDER 8'h11
`define ADDR_CLK_SCALERS 8'h12
`define ADDR_SUPPLY_TUNING 8'h13
`define ADDR_FAULT_STATUS 8'h14
`define ADDR_TX_CONTROL 8'h15
`define RESET_BYTE 8'h00
`define RESET_SOURCE 3'h0
`define OVERRIDE_BIT 5
`define FLAG_LOCK 0
`define FLAG_VCO 1
`define FLAG_UV 2
`define SRC_REF16 2'h0
`define SRC_PRESCALE 2'h1
`define SRC_DIVIDED 2'h2
`define SRC_INVERTED 2'h3
`define LOCK_WINDOW 8'h3f
`define LOCK_LIMIT 8'h02
`define VCO_CAL_LIMIT 8'hf0
`define CLK_MHZ 250
`define SETTLE_TIME_US 100
`endif

// file: rtl/tx_pkg.sv
// types shared by the transmitter control block
package tx_pkg;
  typedef enum logic [1:0] {mode_standby, mode_settle, mode_transmit} mode_type;
  typedef struct packed {
    logic ask;
    logic high_range;
    logic [5:0] high_level_power;
  } profile_type;
  typedef struct packed {
    logic amplifier_on_state;
    logic ask;
    logic high_range;
    logic [1:0] amplifier_duty_code;
    logic [5:0] level;
  } amp_ctrl_type;
  typedef struct packed {
    logic out;
    logic oe_n;
  } pin_type;
endpackage : tx_pkg

// file: rtl/tx_power_failsafe_clockout.sv
// amplifier profile, fail-safe and clock output control of the transmitter
// Functional notes
// (RULE1) two profiles, chosen by transmit command bit
// (RULE2) profile type bit: 0 fsk, 1 ask
// (RULE3) profile range bit: 0 low, 1 high
// (RULE4) high level power for ask high, fsk
// (RULE5) low level power, zero turns amplifier off
// (RULE6) duty code output; host avoids illegal codes
// (RULE7) ramp steps every ramp-rate cycles
// (RULE8) ramp also shapes fsk amplifier start
// (RULE9) five-bit antenna tuning code at 0x13
// (RULE10) fault flags readable, cleared by write
// (RULE11) override low: fault stops amplifier
// (RULE12) flags set keep amplifier off at entry; code keeps it off only with override low, override high lets it run
// (RULE13) lock detector counts only in transmit
// (RULE14) vco calibration checked during settling interval
// (RULE15) undervoltage flag from detect until release
// (RULE16) sources 000 to 011 clock selection; 010, 011 drive static 0, 1 when off
// (RULE17) sources 100 to 111 high-z when off
// (RULE18) source field resets to 000
// (RULE19) prescaler divides by two to code
// (RULE20) comparator divides by value plus one
// (RULE21) afterscaler divides by 1,2,4,8
// (RULE22) divider chain yields bitrate strobe
// (RULE23) prescaler, comparator, afterscaler in cascade
// (RULE24) register writes refused outside standby
`timescale 1ns/1ps
`default_nettype none
`include "tx_consts.svh"
module tx_power_failsafe_clockout #(
  parameter int SETTLE_CYCLES = `SETTLE_TIME_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_we,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic tx_cmd,
  input wire logic tx_cmd_profile,
  input wire logic tx_stop,
  input wire logic data_bit,
  input wire logic pll_ref_tick,
  input wire logic pll_fb_tick,
  input wire logic vco_cal_done,
  input wire logic [7:0] vco_cal_result,
  input wire logic supply_below_detect,
  input wire logic supply_above_release,
  output tx_pkg::amp_ctrl_type amp_ctrl,
  output logic [4:0] antenna_tuning_code,
  output logic [1:0] undervoltage_threshold_select,
  output tx_pkg::mode_type mode,
  output tx_pkg::pin_type clock_output_pin,
  output logic bitrate_strobe
);
  import tx_pkg::*;

  mode_type mode_reg, mode_next;
  logic [7:0] profile_zero_reg, profile_one_reg, low_duty_reg, ramp_rate_reg;
  logic [7:0] cmp_div_reg, scalers_reg, tuning_reg, control_reg;
  logic [2:0] flags_reg, flags_next;
  logic select_reg;
  logic [15:0] settle_cnt_reg;
  logic [7:0] ref_cnt_reg, fb_cnt_reg;
  logic uv_active_reg;
  logic [5:0] level_reg;
  logic [7:0] ramp_cnt_reg;
  logic [3:0] ref16_cnt_reg;
  logic [6:0] psc_cnt_reg;
  logic [7:0] cmp_cnt_reg;
  logic [2:0] asc_cnt_reg;
  logic psc_wave_reg, div_wave_reg, bitrate_reg;
  logic [7:0] rdata_reg;
  pin_type pin_reg;

  // register decode; writes only land in standby
  wire write_ok = reg_we && mode_reg == mode_standby; // RULE24
  wire wr_p0 = write_ok && reg_addr == `ADDR_PROFILE_ZERO;
  wire wr_p1 = write_ok && reg_addr == `ADDR_PROFILE_ONE;
  wire wr_low = write_ok && reg_addr == `ADDR_LOW_POWER_DUTY;
  wire wr_ramp = write_ok && reg_addr == `ADDR_RAMP_RATE;
  wire wr_cmp = write_ok && reg_addr == `ADDR_CMP_DIVIDER;
  wire wr_scl = write_ok && reg_addr == `ADDR_CLK_SCALERS;
  wire wr_tun = write_ok && reg_addr == `ADDR_SUPPLY_TUNING;
  wire wr_stat = write_ok && reg_addr == `ADDR_FAULT_STATUS;
  wire wr_ctl = write_ok && reg_addr == `ADDR_TX_CONTROL;

  // selected profile fields
  wire profile_type prof = select_reg ? profile_one_reg : profile_zero_reg; // RULE1
  wire [5:0] low_level_power = low_duty_reg[5:0];
  wire [1:0] amplifier_duty_code = low_duty_reg[7:6]; // RULE6
  wire [2:0] clock_output_source = scalers_reg[7:5];
  wire [2:0] prescaler_code = scalers_reg[4:2];
  wire [1:0] afterscaler_code = scalers_reg[1:0];
  wire failsafe_override = control_reg[`OVERRIDE_BIT];

  // amplifier gating by fail-safe policy
  wire fault_block = |flags_reg && !failsafe_override; // RULE11 RULE12
  wire amplifier_on_state = mode_reg == mode_transmit && !fault_block;

  // state sequence
  wire settle_done = settle_cnt_reg == 16'(SETTLE_CYCLES - 1);
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      mode_standby: if (tx_cmd) mode_next = mode_settle;
      mode_settle: begin
        if (tx_stop) mode_next = mode_standby;
        else if (settle_done) mode_next = mode_transmit;
      end
      mode_transmit: if (tx_stop) mode_next = mode_standby;
    endcase
  end

  // lock detector over a window of reference ticks
  wire in_tx = mode_reg == mode_transmit;
  wire window_end = in_tx && ref_cnt_reg == `LOCK_WINDOW;
  wire [7:0] lock_diff = ref_cnt_reg > fb_cnt_reg ? ref_cnt_reg - fb_cnt_reg
                                                 : fb_cnt_reg - ref_cnt_reg;
  wire lock_err = window_end && lock_diff > `LOCK_LIMIT; // RULE13
  wire vco_err = mode_reg == mode_settle && vco_cal_done
                 && vco_cal_result > `VCO_CAL_LIMIT; // RULE14

  // set beats the write clear
  always_comb begin
    flags_next = wr_stat ? 3'h0 : flags_reg; // RULE10
    if (lock_err) flags_next[`FLAG_LOCK] = 1'b1;
    if (vco_err) flags_next[`FLAG_VCO] = 1'b1;
    if (uv_active_reg) flags_next[`FLAG_UV] = 1'b1; // RULE15
  end

  // ramp target: ask follows data, fsk holds high level
  wire [5:0] ramp_target = !amplifier_on_state ? 6'h00
                         : (prof.ask && !data_bit) ? low_level_power // RULE2 RULE5
                         : prof.high_level_power; // RULE4
  wire ramp_step = ramp_cnt_reg + 8'h01 >= ramp_rate_reg; // RULE7

  // divider chain
  wire [6:0] psc_mask = 7'((8'h01 << prescaler_code) - 8'h01);
  wire psc_tick = (psc_cnt_reg & psc_mask) == psc_mask; // RULE19
  // at or above, so lowering the value mid-count cannot force a 256-step wrap
  wire cmp_tick = psc_tick && cmp_cnt_reg >= cmp_div_reg; // RULE20 RULE23
  wire [2:0] asc_mask = 3'((4'h1 << afterscaler_code) - 4'h1);
  wire asc_tick = cmp_tick && (asc_cnt_reg & asc_mask) == asc_mask; // RULE21

  // clock output selection
  logic sel_wave;
  always_comb begin
    unique case (clock_output_source[1:0])
      `SRC_REF16: sel_wave = ref16_cnt_reg[3];
      `SRC_PRESCALE: sel_wave = psc_wave_reg;
      `SRC_DIVIDED: sel_wave = div_wave_reg;
      `SRC_INVERTED: sel_wave = !div_wave_reg;
    endcase
  end
  pin_type pin_next;
  always_comb begin
    pin_next.oe_n = 1'b0;
    pin_next.out = sel_wave;
    if (!amplifier_on_state) begin
      if (clock_output_source[2]) pin_next.oe_n = 1'b1; // RULE17
      else if (clock_output_source[1]) pin_next.out = clock_output_source[0]; // RULE16
    end
  end

  // register readback
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      `ADDR_PROFILE_ZERO: rd_mux = profile_zero_reg;
      `ADDR_PROFILE_ONE: rd_mux = profile_one_reg;
      `ADDR_LOW_POWER_DUTY: rd_mux = low_duty_reg;
      `ADDR_RAMP_RATE: rd_mux = ramp_rate_reg;
      `ADDR_CMP_DIVIDER: rd_mux = cmp_div_reg;
      `ADDR_CLK_SCALERS: rd_mux = scalers_reg;
      `ADDR_SUPPLY_TUNING: rd_mux = tuning_reg;
      `ADDR_FAULT_STATUS: rd_mux = {5'h00, flags_reg}; // RULE10
      `ADDR_TX_CONTROL: rd_mux = control_reg;
      default: rd_mux = `RESET_BYTE;
    endcase
  end

  // rst stands for power-down entry
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      profile_zero_reg <= `RESET_BYTE;
      profile_one_reg <= `RESET_BYTE;
      low_duty_reg <= `RESET_BYTE;
      ramp_rate_reg <= `RESET_BYTE;
      cmp_div_reg <= `RESET_BYTE;
      scalers_reg <= {`RESET_SOURCE, 5'h00}; // RULE18
      tuning_reg <= `RESET_BYTE;
      control_reg <= `RESET_BYTE;
    end else begin
      if (wr_p0) profile_zero_reg <= reg_wdata;
      if (wr_p1) profile_one_reg <= reg_wdata;
      if (wr_low) low_duty_reg <= reg_wdata;
      if (wr_ramp) ramp_rate_reg <= reg_wdata;
      if (wr_cmp) cmp_div_reg <= reg_wdata;
      if (wr_scl) scalers_reg <= reg_wdata;
      if (wr_tun) tuning_reg <= reg_wdata; // RULE9
      if (wr_ctl) control_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= mode_standby;
      select_reg <= 1'b0;
      settle_cnt_reg <= 16'h0000;
      flags_reg <= 3'h0;
      uv_active_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      if (mode_reg == mode_standby && tx_cmd) select_reg <= tx_cmd_profile; // RULE1
      settle_cnt_reg <= mode_reg == mode_settle ? settle_cnt_reg + 16'h0001 : 16'h0000;
      flags_reg <= flags_next;
      if (supply_below_detect) uv_active_reg <= 1'b1;
      else if (supply_above_release) uv_active_reg <= 1'b0;
    end
  end

  // frequencies compared only while transmitting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_cnt_reg <= 8'h00;
      fb_cnt_reg <= 8'h00;
    end else if (!in_tx || window_end) begin
      ref_cnt_reg <= 8'h00;
      fb_cnt_reg <= 8'h00;
    end else begin
      ref_cnt_reg <= ref_cnt_reg + 8'(pll_ref_tick);
      fb_cnt_reg <= fb_cnt_reg + 8'(pll_fb_tick);
    end
  end

  // level ramps one code per step, also from zero at start-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_reg <= 6'h00;
      ramp_cnt_reg <= 8'h00;
    end else if (!amplifier_on_state) begin
      level_reg <= 6'h00; // RULE11
      ramp_cnt_reg <= 8'h00;
    end else if (level_reg == ramp_target) begin
      ramp_cnt_reg <= 8'h00;
    end else if (ramp_step) begin
      level_reg <= level_reg < ramp_target ? level_reg + 6'h01 // RULE7 RULE8
                                           : level_reg - 6'h01;
      ramp_cnt_reg <= 8'h00;
    end else begin
      ramp_cnt_reg <= ramp_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref16_cnt_reg <= 4'h0;
      psc_cnt_reg <= 7'h00;
      cmp_cnt_reg <= 8'h00;
      asc_cnt_reg <= 3'h0;
      psc_wave_reg <= 1'b0;
      div_wave_reg <= 1'b0;
      bitrate_reg <= 1'b0;
    end else begin
      ref16_cnt_reg <= ref16_cnt_reg + 4'h1;
      psc_cnt_reg <= psc_cnt_reg + 7'h01;
      if (psc_tick) begin
        psc_wave_reg <= !psc_wave_reg;
        cmp_cnt_reg <= cmp_tick ? 8'h00 : cmp_cnt_reg + 8'h01;
      end
      if (cmp_tick) asc_cnt_reg <= asc_cnt_reg + 3'h1;
      if (asc_tick) div_wave_reg <= !div_wave_reg; // RULE23
      bitrate_reg <= asc_tick; // RULE22
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_reg <= '{out: 1'b0, oe_n: 1'b0};
      rdata_reg <= `RESET_BYTE;
    end else begin
      pin_reg <= pin_next;
      rdata_reg <= rd_mux;
    end
  end

  assign reg_rdata = rdata_reg;
  assign clock_output_pin = pin_reg;
  assign bitrate_strobe = bitrate_reg;
  assign mode = mode_reg;
  assign antenna_tuning_code = tuning_reg[4:0]; // RULE9
  assign undervoltage_threshold_select = tuning_reg[6:5]; // RULE15
  // level of zero also means the amplifier output is off
  assign amp_ctrl = '{amplifier_on_state: amplifier_on_state && level_reg != 6'h00,
                      ask: prof.ask, high_range: prof.high_range, // RULE2 RULE3
                      amplifier_duty_code: amplifier_duty_code, level: level_reg};

  property p_write_refused;
    @(posedge clk) disable iff (rst)
    reg_we && mode_reg != mode_standby |=> $stable(profile_zero_reg) && $stable(control_reg);
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("write taken outside standby"); // RULE24
  property p_flag_clear;
    @(posedge clk) disable iff (rst)
    wr_stat && !lock_err && !vco_err && !uv_active_reg |=> flags_reg == 3'h0;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("status write did not clear"); // RULE10
  property p_fault_off;
    @(posedge clk) disable iff (rst)
    |flags_reg && !failsafe_override |-> !amp_ctrl.amplifier_on_state ##1 level_reg == 6'h00;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("amplifier ran with fault"); // RULE11
  property p_override_runs;
    @(posedge clk) disable iff (rst)
    in_tx && failsafe_override |-> amplifier_on_state;
  endproperty
  a_override_runs: assert property (p_override_runs) else $error("override ignored"); // RULE12
  property p_lock_in_tx;
    @(posedge clk) disable iff (rst)
    $rose(flags_reg[`FLAG_LOCK]) |-> $past(mode_reg) == mode_transmit;
  endproperty
  a_lock_in_tx: assert property (p_lock_in_tx) else $error("lock flag outside transmit"); // RULE13
  property p_vco_flag;
    @(posedge clk) disable iff (rst)
    vco_err |=> flags_reg[`FLAG_VCO];
  endproperty
  a_vco_flag: assert property (p_vco_flag) else $error("calibration error lost"); // RULE14
  property p_uv_flag;
    @(posedge clk) disable iff (rst)
    supply_below_detect |=> ##1 flags_reg[`FLAG_UV];
  endproperty
  a_uv_flag: assert property (p_uv_flag) else $error("undervoltage not flagged"); // RULE15
  property p_highz;
    @(posedge clk) disable iff (rst)
    clock_output_source[2] && !amplifier_on_state |=> clock_output_pin.oe_n;
  endproperty
  a_highz: assert property (p_highz) else $error("clock pin driven while off"); // RULE17
  property p_settle_len;
    @(posedge clk) disable iff (rst)
    $rose(mode_reg == mode_transmit) |-> $past(settle_done);
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("transmit before settling"); // RULE14
  c_tx: cover property (@(posedge clk) disable iff (rst) $rose(amplifier_on_state));
  c_fault: cover property (@(posedge clk) disable iff (rst) in_tx && $rose(fault_block));
  c_bitrate: cover property (@(posedge clk) disable iff (rst) bitrate_strobe);
endmodule : tx_power_failsafe_clockout
`default_nettype wire

// file: verif/pll_model.sv
// stand-in for the pll, its calibration and lock feedback
`timescale 1ns/1ps
`default_nettype none
module pll_model (
  input wire logic clk,
  input wire logic rst,
  input wire tx_pkg::mode_type mode,
  input wire logic fb_slow,
  input wire logic cal_bad,
  output logic pll_ref_tick,
  output logic pll_fb_tick,
  output logic vco_cal_done,
  output logic [7:0] vco_cal_result
);
  import tx_pkg::*;
  logic [2:0] cnt_reg;
  logic settle_seen_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 3'h0;
      settle_seen_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      settle_seen_reg <= (mode == mode_settle);
    end
  end
  assign pll_ref_tick = cnt_reg[1:0] == 2'h3;
  // half-rate feedback stands for a pll out of lock
  assign pll_fb_tick = fb_slow ? (cnt_reg == 3'h7) : (cnt_reg[1:0] == 2'h3);
  // one calibration answer at the start of each settle interval
  assign vco_cal_done = (mode == mode_settle) && !settle_seen_reg;
  assign vco_cal_result = cal_bad ? 8'hff : 8'h40;
endmodule : pll_model
`default_nettype wire

// file: verif/tx_power_failsafe_clockout_test.sv
// self-checking bench of the transmitter control block
`timescale 1ns/1ps
`default_nettype none
module tx_power_failsafe_clockout_test;
  import tx_pkg::*;
  logic clk, rst, reg_we, tx_cmd, tx_cmd_profile, tx_stop, data_bit;
  logic fb_slow, cal_bad, supply_below_detect, supply_above_release;
  logic pll_ref_tick, pll_fb_tick, vco_cal_done, bitrate_strobe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, vco_cal_result, rd, lowp, d;
  logic [7:0] prof [2];
  logic [4:0] antenna_tuning_code;
  logic [1:0] undervoltage_threshold_select, psc, asc;
  amp_ctrl_type amp_ctrl;
  mode_type mode;
  pin_type clock_output_pin;
  int fail_count = 0;
  int samples_checked = 0;
  int seed = 32'h1423d166;
  int n, k, g, p;
  tx_power_failsafe_clockout #(.SETTLE_CYCLES(20)) tx_power_failsafe_clockout_i (
    .clk(clk), .rst(rst), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .tx_cmd(tx_cmd), .tx_cmd_profile(tx_cmd_profile),
    .tx_stop(tx_stop), .data_bit(data_bit), .pll_ref_tick(pll_ref_tick),
    .pll_fb_tick(pll_fb_tick), .vco_cal_done(vco_cal_done),
    .vco_cal_result(vco_cal_result), .supply_below_detect(supply_below_detect),
    .supply_above_release(supply_above_release), .amp_ctrl(amp_ctrl),
    .antenna_tuning_code(antenna_tuning_code),
    .undervoltage_threshold_select(undervoltage_threshold_select), .mode(mode),
    .clock_output_pin(clock_output_pin), .bitrate_strobe(bitrate_strobe));
  pll_model pll_model_i (.clk(clk), .rst(rst), .mode(mode), .fb_slow(fb_slow),
    .cal_bad(cal_bad), .pll_ref_tick(pll_ref_tick), .pll_fb_tick(pll_fb_tick),
    .vco_cal_done(vco_cal_done), .vco_cal_result(vco_cal_result));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rdreg(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    tick();
    tick();
    rd = reg_rdata;
  endtask : rdreg
  task automatic wait_mode(input mode_type m);
    for (n = 0; n < 200 && mode !== m; n++) tick();
    if (mode !== m) begin
      fail_count++;
      $display("mismatch at %0t: mode wait ran out", $time);
      end_of_test();
    end
  endtask : wait_mode
  task automatic tx(input logic sel);
    @(posedge clk);
    tx_cmd <= 1'b1;
    tx_cmd_profile <= sel;
    @(posedge clk);
    tx_cmd <= 1'b0;
    wait_mode(mode_transmit);
  endtask : tx
  task automatic stop();
    @(posedge clk);
    tx_stop <= 1'b1;
    @(posedge clk);
    tx_stop <= 1'b0;
    wait_mode(mode_standby);
  endtask : stop
  // cycles between two strobes, or two edges of the pin
  task automatic gap(input bit s);
    logic last;
    g = 0;
    for (k = 0; k < 3000; k++) begin
      last = clock_output_pin.out;
      tick();
      if (s ? bitrate_strobe === 1'b1 : clock_output_pin.out !== last) begin
        if (g > 0) break;
        g = 1;
      end else if (g > 0) g++;
    end
    if (k == 3000) begin
      fail_count++;
      $display("mismatch at %0t: edge wait ran out", $time);
      end_of_test();
    end
  endtask : gap
  function automatic logic [5:0] exp_level(input logic [7:0] pr, input logic b);
    return (pr[7] && !b) ? lowp[5:0] : pr[5:0];
  endfunction : exp_level
  initial begin
    {rst, reg_we, tx_cmd, tx_cmd_profile, tx_stop, data_bit} = 6'h21;
    {fb_slow, cal_bad, supply_below_detect, supply_above_release} = 4'h1;
    {reg_addr, reg_wdata} = 16'h0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdreg(8'h12);
    check(rd, 8'h00);
    gap(0);
    check(16'(g), 16'h8);
    rdreg(8'h14);
    check(rd, 8'h00);
    prof[0] = 8'($random(seed));
    prof[1] = 8'($random(seed)) | 8'h80;
    lowp = 8'($random(seed));
    d = 8'($random(seed));
    wr(8'h0c, prof[0]);
    wr(8'h0d, prof[1]);
    wr(8'h0e, lowp);
    wr(8'h13, d);
    rdreg(8'h0d);
    check(rd, prof[1]);
    rdreg(8'h10);
    check(rd, 8'h00);
    check(antenna_tuning_code, d[4:0]);
    check(undervoltage_threshold_select, d[6:5]);
    for (p = 0; p < 4; p++) begin
      psc = 2'($random(seed));
      asc = 2'($random(seed));
      d = 8'($random(seed)) & 8'h07;
      wr(8'h11, d);
      wr(8'h12, {3'h1, 1'b0, psc, asc});
      gap(1);
      check(16'(g), 16'((1 << psc) * (d + 1) * (1 << asc)));
      gap(0);
      check(16'(g), 16'(1 << psc));
    end
    wr(8'h12, 8'h80);
    repeat (3) tick();
    check(clock_output_pin.oe_n, 1'b1);
    wr(8'h12, 8'h40);
    repeat (3) tick();
    check({clock_output_pin.out, clock_output_pin.oe_n}, 2'b00);
    wr(8'h12, 8'h60);
    repeat (3) tick();
    check({clock_output_pin.out, clock_output_pin.oe_n}, 2'b10);
    wr(8'h12, 8'h80);
    wr(8'h0f, 8'h01);
    for (p = 0; p < 2; p++) begin
      data_bit <= 1'(p == 0);
      tx(1'(p));
      repeat (80) tick();
      check(16'(exp_level(prof[p], data_bit) != 6'h00), amp_ctrl.amplifier_on_state);
      check(clock_output_pin.oe_n, 1'b0);
      gap(0);
      check(16'(g), 16'h8);
      check(amp_ctrl.ask, prof[p][7]);
      check(amp_ctrl.high_range, prof[p][6]);
      check(amp_ctrl.amplifier_duty_code, lowp[7:6]);
      check(amp_ctrl.level, exp_level(prof[p], data_bit));
      wr(8'h0c, ~prof[0]);
      rdreg(8'h0c);
      check(rd, prof[0]);
      stop();
    end
    cal_bad <= 1'b1;
    tx(1'b0);
    repeat (10) tick();
    check(amp_ctrl.amplifier_on_state, 1'b0);
    check(clock_output_pin.oe_n, 1'b1);
    rdreg(8'h14);
    check(rd[1], 1'b1);
    stop();
    cal_bad <= 1'b0;
    tx(1'b0);
    repeat (10) tick();
    check(amp_ctrl.amplifier_on_state, 1'b0);
    stop();
    wr(8'h14, 8'h00);
    rdreg(8'h14);
    check(rd, 8'h00);
    fb_slow <= 1'b1;
    repeat (600) tick();
    rdreg(8'h14);
    check(rd[0], 1'b0);
    wr(8'h15, 8'h20);
    tx(1'b0);
    repeat (600) tick();
    rdreg(8'h14);
    check(rd[0], 1'b1);
    check(amp_ctrl.amplifier_on_state, 16'(exp_level(prof[0], data_bit) != 6'h00));
    stop();
    fb_slow <= 1'b0;
    wr(8'h14, 8'h00);
    {supply_below_detect, supply_above_release} <= 2'b10;
    repeat (3) tick();
    {supply_below_detect, supply_above_release} <= 2'b01;
    rdreg(8'h14);
    check(rd[2], 1'b1);
    repeat (3) tick();
    wr(8'h14, 8'h00);
    rdreg(8'h14);
    check(rd, 8'h00);
    end_of_test();
  end
endmodule : tx_power_failsafe_clockout_test
`default_nettype wire
